// ### core/pio_computer.sv
// computer end of the pio bus: command sequencer and control lines
`timescale 1ns/1ns
`default_nettype none
`include "pio_defs.svh"
module pio_computer
  import pio_pkg::*;
#(
  parameter int POWER_FAIL_WARNING_LEAD_CYC = `PIO_POWER_FAIL_WARNING_LEAD_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  pio_bus_if.computer bus,
  input wire logic cmd_valid,
  input wire logic [5:0] cmd_opcode,
  input wire logic [1:0] cmd_kind,
  input wire logic [9:0] cmd_addr,
  input wire logic [15:0] cmd_acc,
  output logic cmd_ready,
  output logic done,
  output logic skip_q,
  output logic acc_load,
  output logic [15:0] acc_q,
  input wire logic dmc_range_end,
  input wire logic clear_req,
  input wire logic power_lost,
  input wire logic power_valid,
  output logic panel_fault,
  output logic irq_pending
);
  // refused at elaboration: a zero lead would give no warning at all
  if (POWER_FAIL_WARNING_LEAD_CYC < 1) begin : g_bad_lead
    $error("power fail lead too short");
  end
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DONE} pio_st_e;
  pio_st_e st_q;
  pio_cmd_e cmd_q;
  logic [7:0] cyc_q;
  logic got_q;
  logic [31:0] pf_cnt_q;
  logic pf_q;
  logic in_pulse;
  // opcode 74 with address 20 or 24 is a mask command
  function automatic pio_cmd_e decode(input logic [5:0] op, input logic [1:0] k,
                                      input logic [5:0] dev);
    if (op == 6'h3C && (dev == `PIO_SMK_LOAD_ADDR || dev == `PIO_SMK_ALT_ADDR))
      return PIO_CMD_MASK;
    unique case (k)
      2'd0: return PIO_CMD_CONTROL;
      2'd1: return PIO_CMD_SENSE;
      2'd2: return PIO_CMD_INPUT;
      default: return PIO_CMD_OUTPUT;
    endcase
  endfunction : decode
  assign cmd_ready = (st_q == ST_IDLE);
  assign in_pulse = (st_q == ST_ADDR) && cyc_q >= `PIO_PULSE_START && cyc_q < `PIO_PULSE_END;
  // command sequencer: one address interval per instruction
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      cmd_q <= PIO_CMD_CONTROL;
      cyc_q <= 8'h00;
      bus.io_address_bus <= 10'h000;
      bus.output_data_bus <= 16'h0000;
    end else if (ce) begin
      unique case (st_q)
        ST_IDLE: if (cmd_valid) begin
          cmd_q <= decode(cmd_opcode, cmd_kind, cmd_addr[5:0]);
          bus.io_address_bus <= cmd_addr;
          bus.output_data_bus <= cmd_acc;
          cyc_q <= 8'h00;
          st_q <= ST_ADDR;
        end
        ST_ADDR: begin
          cyc_q <= cyc_q + 8'h01;
          if (cyc_q == `PIO_ADDR_CYC - 8'h01) st_q <= ST_DONE;
        end
        ST_DONE: begin
          bus.io_address_bus <= 10'h000;
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
  // ready sampling, skip decision and accumulator load
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      got_q <= 1'b0;
      skip_q <= 1'b0;
      acc_q <= 16'h0000;
      acc_load <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      acc_load <= 1'b0;
      done <= (st_q == ST_DONE);
      if (st_q == ST_IDLE && cmd_valid) begin
        got_q <= 1'b0;
        skip_q <= 1'b0;
      end
      if (st_q == ST_ADDR && cyc_q < `PIO_READY_LATE && bus.device_ready_line) begin
        // control commands never look at ready
        if (cmd_q == PIO_CMD_SENSE || cmd_q == PIO_CMD_INPUT || cmd_q == PIO_CMD_OUTPUT)
          got_q <= 1'b1;
      end
      // load on the last pulse cycle, while the interface still drives the word
      if (st_q == ST_ADDR && cyc_q == `PIO_PULSE_END - 8'h01 && got_q) begin
        skip_q <= (cmd_q != PIO_CMD_OUTPUT);
        if (cmd_q == PIO_CMD_INPUT) begin
          acc_q <= bus.input_data_bus;
          acc_load <= 1'b1;
        end
      end
    end
  end
  // strobe pulses within the late half of the address interval
  always_comb begin
    bus.output_control_pulse = in_pulse && cmd_q == PIO_CMD_CONTROL;
    bus.reset_ready_pulse = in_pulse && got_q &&
                            (cmd_q == PIO_CMD_INPUT || cmd_q == PIO_CMD_OUTPUT);
    bus.mask_instruction_flag = (st_q == ST_ADDR) && cmd_q == PIO_CMD_MASK;
    bus.mask_clear_pulse = (st_q == ST_ADDR) && cmd_q == PIO_CMD_MASK &&
                           cyc_q == `PIO_PULSE_START - 8'h02;
    bus.mask_load_strobe = in_pulse && cmd_q == PIO_CMD_MASK &&
                           bus.io_address_bus[5:0] == `PIO_SMK_LOAD_ADDR;
  end
  // range end, master clear and panel lines
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus.dma_range_end_pulse <= 1'b0;
      bus.master_clear_level <= 1'b1;
      panel_fault <= 1'b0;
      irq_pending <= 1'b0;
    end else if (ce) begin
      bus.dma_range_end_pulse <= dmc_range_end;
      bus.master_clear_level <= clear_req;
      panel_fault <= bus.parity_fault_level;
      irq_pending <= bus.interrupt_request_level;
    end
  end
  // power warning: low held a lead time before supply loss, active low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pf_q <= 1'b0;
      pf_cnt_q <= 32'h0000_0000;
    end else if (ce) begin
      // lead counter runs while the warning is out
      if (pf_q && pf_cnt_q < POWER_FAIL_WARNING_LEAD_CYC) pf_cnt_q <= pf_cnt_q + 32'h0000_0001;
      if (power_lost) begin
        pf_q <= 1'b1;
      end else if (power_valid && pf_cnt_q >= POWER_FAIL_WARNING_LEAD_CYC) begin
        // a warning once raised stands for the whole lead time
        pf_q <= 1'b0;
        pf_cnt_q <= 32'h0000_0000;
      end
    end
  end
  assign bus.power_fail_warning_n = !pf_q;
endmodule : pio_computer
`default_nettype wire

// ### core/pio_defs.svh
// pio bus timing, field positions and mask address constants
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH
`define PIO_CLK_PERIOD_NS 4
`define PIO_ADDR_W 10
`define PIO_DATA_W 16
`define PIO_DEV_W 6
`define PIO_FUNC_LSB 6
`define PIO_FUNC_W 4
`define PIO_SMK_LOAD_ADDR 6'h10
`define PIO_SMK_ALT_ADDR 6'h14
`define PIO_ADDR_CYC 8'd16
`define PIO_PULSE_START 8'd10
`define PIO_PULSE_END 8'd13
`define PIO_READY_LATE 8'd12
`define PIO_READY_LAST 8'd14
`define PIO_POWER_FAIL_WARNING_LEAD_US 1000
`define PIO_POWER_FAIL_WARNING_LEAD_CYC ((`PIO_POWER_FAIL_WARNING_LEAD_US * 1000) / `PIO_CLK_PERIOD_NS)
`endif

// ### core/pio_pkg.sv
// pio bus shared types
package pio_pkg;
  // i/o command kinds
  typedef enum logic [2:0] {
    PIO_CMD_CONTROL,
    PIO_CMD_SENSE,
    PIO_CMD_INPUT,
    PIO_CMD_OUTPUT,
    PIO_CMD_MASK
  } pio_cmd_e;
endpackage : pio_pkg

// ### core/pio_bus_if.sv
// pio bus carrier joining computer end and interface end
`timescale 1ns/1ns
`default_nettype none
interface pio_bus_if;
  logic [9:0] io_address_bus;
  logic [15:0] output_data_bus;
  logic [15:0] input_data_bus;
  logic input_data_en;
  logic output_control_pulse;
  logic reset_ready_pulse;
  logic mask_instruction_flag;
  logic mask_load_strobe;
  logic mask_clear_pulse;
  logic device_ready_line;
  logic interrupt_request_level;
  logic parity_fault_level;
  logic dma_range_end_pulse;
  logic master_clear_level;
  logic power_fail_warning_n;
  modport computer (
    output io_address_bus, output_data_bus, output_control_pulse, reset_ready_pulse,
    output mask_instruction_flag, mask_load_strobe, mask_clear_pulse,
    output dma_range_end_pulse, master_clear_level, power_fail_warning_n,
    input input_data_bus, input_data_en, device_ready_line, interrupt_request_level,
    input parity_fault_level
  );
  modport periph (
    input io_address_bus, output_data_bus, output_control_pulse, reset_ready_pulse,
    input mask_instruction_flag, mask_load_strobe, mask_clear_pulse,
    input dma_range_end_pulse, master_clear_level, power_fail_warning_n,
    output input_data_bus, input_data_en, device_ready_line, interrupt_request_level,
    output parity_fault_level
  );
endinterface : pio_bus_if
`default_nettype wire

// ### core/pio_periph.sv
// peripheral control interface end of the pio bus
`timescale 1ns/1ns
`default_nettype none
`include "pio_defs.svh"
module pio_periph
  import pio_pkg::*;
#(
  parameter logic [5:0] DEV_ADDR = 6'h01,
  parameter int MASK_BIT = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  pio_bus_if.periph bus,
  input wire logic rx_valid,
  input wire logic [15:0] rx_data,
  input wire logic tx_taken,
  input wire logic sense_cond,
  input wire logic parity_err,
  output logic tx_valid,
  output logic [15:0] tx_data,
  output logic [3:0] ctl_func,
  output logic ctl_stb,
  output logic mask_q,
  output logic out_mode_q,
  output logic clear_seen
);
  // refused at elaboration: only output bus bits 1..15 carry mask bits
  if (MASK_BIT < 1 || MASK_BIT > 15) begin : g_bad_mask_bit
    $error("mask bit out of range");
  end
  logic sel;
  logic [3:0] func;
  logic ready_q;
  logic [15:0] buf_q;
  logic rrp_q;
  logic mclr;
  assign sel = bus.io_address_bus[`PIO_DEV_W-1:0] == DEV_ADDR;
  assign func = bus.io_address_bus[`PIO_FUNC_LSB +: `PIO_FUNC_W];
  assign mclr = bus.master_clear_level;
  assign clear_seen = mclr;
  // control action on pulse; func 1 selects output mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_stb <= 1'b0;
      ctl_func <= 4'h0;
      out_mode_q <= 1'b0;
    end else if (ce) begin
      ctl_stb <= sel && bus.output_control_pulse;
      if (sel && bus.output_control_pulse) begin
        ctl_func <= func;
        out_mode_q <= (func == 4'h1);
      end
      if (mclr) out_mode_q <= 1'b0;
    end
  end
  // mask flip-flop: clear pulse then load strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) mask_q <= 1'b0;
    else if (ce) begin
      if (mclr || bus.mask_clear_pulse) mask_q <= 1'b0;
      else if (bus.mask_load_strobe) mask_q <= bus.output_data_bus[MASK_BIT];
    end
  end
  // ready and buffer; ready cleared by reset ready pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ready_q <= 1'b0;
      buf_q <= 16'h0000;
      rrp_q <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 16'h0000;
    end else if (ce) begin
      rrp_q <= sel && bus.reset_ready_pulse;
      if (tx_taken) tx_valid <= 1'b0;
      if (mclr) begin
        ready_q <= 1'b0;
        tx_valid <= 1'b0;
      end else if (sel && bus.reset_ready_pulse) begin
        ready_q <= 1'b0;
        if (out_mode_q) begin
          tx_data <= bus.output_data_bus;
          tx_valid <= 1'b1;
        end
      end else if (rrp_q && !out_mode_q) begin
        buf_q <= 16'h0000; // trailing edge frees the buffer
      end else if (!out_mode_q && rx_valid && !ready_q) begin
        buf_q <= rx_data;
        ready_q <= 1'b1;
      end else if (out_mode_q && !ready_q && !tx_valid) begin
        ready_q <= 1'b1;
      end
    end
  end
  // shared lines driven only while addressed
  always_comb begin
    bus.device_ready_line = 1'b0;
    bus.input_data_en = 1'b0;
    bus.input_data_bus = 16'h0000;
    if (sel && !mclr) begin
      bus.device_ready_line = (func == 4'h0) ? ready_q : sense_cond;
      // word stays on the bus until the reset ready pulse ends
      if (!out_mode_q && (ready_q || bus.reset_ready_pulse)) begin
        bus.input_data_en = 1'b1;
        bus.input_data_bus = buf_q;
      end
    end
  end
  assign bus.interrupt_request_level = mask_q && ready_q && !mclr;
  assign bus.parity_fault_level = parity_err;
endmodule : pio_periph
`default_nettype wire

// ### tb/pio_bus_monitor.sv
// concurrent checks on the pio bus wires
`timescale 1ns/1ns
`default_nettype none
module pio_bus_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [9:0] io_address_bus,
  input wire logic output_control_pulse,
  input wire logic reset_ready_pulse,
  input wire logic mask_instruction_flag,
  input wire logic mask_load_strobe,
  input wire logic mask_clear_pulse,
  input wire logic device_ready_line,
  input wire logic input_data_en,
  input wire logic master_clear_level
);
  // one clock domain, so one default for all
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  ctl_width_a: assert property (
    $rose(output_control_pulse) |-> output_control_pulse[*3] ##1 !output_control_pulse)
    else $error("control pulse width wrong");
  rr_width_a: assert property (
    $rose(reset_ready_pulse) |-> reset_ready_pulse[*3] ##1 !reset_ready_pulse)
    else $error("reset ready width wrong");
  load_needs_flag_a: assert property (
    mask_load_strobe |-> mask_instruction_flag && io_address_bus[5:0] == 6'h10)
    else $error("mask load outside mask set");
  addr_hold_a: assert property (
    $rose(output_control_pulse) |-> $stable(io_address_bus)[*3])
    else $error("address moved under pulse");
  rr_after_ready_a: assert property (
    $rose(reset_ready_pulse) |-> $past(device_ready_line))
    else $error("reset ready without ready");
  ctl_no_rr_a: assert property (
    output_control_pulse |-> !reset_ready_pulse && !mask_load_strobe)
    else $error("transfer strobe in control");
  data_hold_a: assert property (
    reset_ready_pulse && input_data_en |=> input_data_en || !reset_ready_pulse)
    else $error("input data dropped early");
  clear_first_a: assert property (
    $rose(mask_instruction_flag) |-> ##[0:12] mask_clear_pulse)
    else $error("no mask clear in mask set");
  mclr_idle_a: assert property (
    master_clear_level[*2] |-> !device_ready_line)
    else $error("ready held in master clear");
endmodule : pio_bus_monitor
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench: computer and interface ends on one carrier
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // row: command, sense level, feed data after the command, data, expected skip
  typedef struct packed {
    logic [1:0] kind;
    logic [9:0] addr;
    logic cond;
    logic feed;
    logic [15:0] data;
    logic skip;
  } pio_row_s;
  localparam logic [5:0] DEV = 6'h05;
  pio_row_s rows [8];
  logic clk, rstn, cmd_valid, cmd_ready, done, skip_q, acc_load, dmc_range_end, clear_req;
  logic power_lost, power_valid, panel_fault, irq_pending, rx_valid, tx_taken, sense_cond;
  logic parity_err, tx_valid, ctl_stb, mask_q, out_mode_q, clear_seen, seen_ctl, seen_ld;
  logic [5:0] cmd_opcode;
  logic [1:0] cmd_kind;
  logic [9:0] cmd_addr;
  logic [15:0] cmd_acc, acc_q, rx_data, tx_data;
  logic [3:0] ctl_func;
  int bad_count, compares, cyc, n;
  ////////////////////////////////////////////////////////////////////////////
  pio_bus_if bus ();
  pio_computer #(.POWER_FAIL_WARNING_LEAD_CYC(10)) i_pio_computer (.clk(clk), .rstn(rstn), .ce(1'b1),
    .bus(bus), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_kind(cmd_kind),
    .cmd_addr(cmd_addr), .cmd_acc(cmd_acc), .cmd_ready(cmd_ready), .done(done),
    .skip_q(skip_q), .acc_load(acc_load), .acc_q(acc_q), .dmc_range_end(dmc_range_end),
    .clear_req(clear_req), .power_lost(power_lost), .power_valid(power_valid),
    .panel_fault(panel_fault), .irq_pending(irq_pending));
  // mask bit 8 is index 8, or index 7 counted from the other end, so the test words set both
  pio_periph #(.DEV_ADDR(DEV), .MASK_BIT(8)) i_pio_periph (.clk(clk), .rstn(rstn),
    .ce(1'b1), .bus(bus), .rx_valid(rx_valid), .rx_data(rx_data), .tx_taken(tx_taken),
    .sense_cond(sense_cond), .parity_err(parity_err), .tx_valid(tx_valid),
    .tx_data(tx_data), .ctl_func(ctl_func), .ctl_stb(ctl_stb), .mask_q(mask_q),
    .out_mode_q(out_mode_q), .clear_seen(clear_seen));
  pio_bus_monitor i_pio_bus_monitor (.clk(clk), .rstn(rstn),
    .io_address_bus(bus.io_address_bus), .output_control_pulse(bus.output_control_pulse),
    .reset_ready_pulse(bus.reset_ready_pulse),
    .mask_instruction_flag(bus.mask_instruction_flag),
    .mask_load_strobe(bus.mask_load_strobe), .mask_clear_pulse(bus.mask_clear_pulse),
    .device_ready_line(bus.device_ready_line), .input_data_en(bus.input_data_en),
    .master_clear_level(bus.master_clear_level));
  ////////////////////////////////////////////////////////////////////////////
  // free-running clock, 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // device hands a word to its interface
  task automatic feed(input logic [15:0] d);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data = d;
    @(negedge clk);
    rx_valid = 1'b0;
  endtask : feed
  // one command, held until taken, then wait for done with strobe capture
  task automatic do_cmd(input logic [1:0] k, input logic [9:0] a, input logic [15:0] d);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_addr = a;
    cmd_acc = d;
    cmd_opcode = (k == 2'd3) ? 6'h3C : 6'h00;
    n = 0;
    do @(posedge clk); while (cmd_ready !== 1'b1 && ++n < 50);
    @(negedge clk);
    cmd_valid = 1'b0;
    seen_ctl = 1'b0;
    seen_ld = 1'b0;
    for (n = 0; n < 30 && done !== 1'b1; n++) begin
      seen_ctl |= (ctl_stb === 1'b1);
      seen_ld |= (acc_load === 1'b1);
      @(negedge clk);
    end
    chk(done, 1'b1);
  endtask : do_cmd
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {cmd_valid, dmc_range_end, clear_req, power_lost, rx_valid, tx_taken} = '0;
    {sense_cond, parity_err, cyc, bad_count, compares} = '0;
    {cmd_opcode, cmd_kind, cmd_addr, cmd_acc, rx_data} = '0;
    power_valid = 1'b1;
    rstn = 1'b0;
    rows[0] = '{2'd0, {4'h1, DEV}, 1'b0, 1'b0, 16'h0000, 1'b0};
    rows[1] = '{2'd3, {4'h0, DEV}, 1'b0, 1'b0, 16'hA5C3, 1'b0};
    // function 0 reports ready, so sense rows ask a condition code
    rows[2] = '{2'd1, {4'h2, DEV}, 1'b1, 1'b0, 16'h0000, 1'b1};
    rows[3] = '{2'd1, {4'h2, DEV}, 1'b0, 1'b0, 16'h0000, 1'b0};
    rows[4] = '{2'd1, {4'h2, 6'h07}, 1'b1, 1'b0, 16'h0000, 1'b0};
    rows[5] = '{2'd0, {4'h0, DEV}, 1'b0, 1'b1, 16'h3C5A, 1'b0};
    rows[6] = '{2'd2, {4'h0, DEV}, 1'b0, 1'b0, 16'h3C5A, 1'b1};
    rows[7] = '{2'd2, {4'h0, DEV}, 1'b0, 1'b0, 16'h3C5A, 1'b0};
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    chk(bus.power_fail_warning_n, 1'b1);
    foreach (rows[i]) begin
      sense_cond = rows[i].cond;
      do_cmd(rows[i].kind, rows[i].addr, rows[i].data);
      // a word fed before this row sets input mode would be refused
      if (rows[i].feed) feed(rows[i].data);
      chk(seen_ctl, rows[i].kind == 2'd0 && rows[i].addr[5:0] == DEV);
      chk(seen_ld, rows[i].kind == 2'd2 && rows[i].skip);
      if (rows[i].kind != 2'd3) chk(skip_q, rows[i].skip);
      if (rows[i].kind == 2'd0) chk(out_mode_q, rows[i].addr[9:6] == 4'h1);
      if (rows[i].kind == 2'd0 && rows[i].addr[5:0] == DEV) begin
        chk(ctl_func, rows[i].addr[9:6]);
      end
      if (rows[i].kind == 2'd3) chk(tx_data, rows[i].data);
      if (rows[i].skip && rows[i].kind == 2'd2) chk(acc_q, rows[i].data);
    end
    // output refused while the buffer is still full, taken once drained
    do_cmd(2'd0, {4'h1, DEV}, 16'h0000);
    do_cmd(2'd3, {4'h0, DEV}, 16'h1111);
    chk(tx_data, 16'hA5C3);
    chk(tx_valid, 1'b1);
    tx_taken = 1'b1;
    @(negedge clk);
    tx_taken = 1'b0;
    do_cmd(2'd3, {4'h0, DEV}, 16'h1111);
    chk(tx_data, 16'h1111);
    // mask load, then the clearing variant without load
    do_cmd(2'd3, {4'h0, 6'h10}, 16'h0180);
    chk(mask_q, 1'b1);
    // drain the word so ready returns and the unmasked request shows
    tx_taken = 1'b1;
    @(negedge clk);
    tx_taken = 1'b0;
    repeat (2) @(negedge clk);
    chk(irq_pending, 1'b1);
    do_cmd(2'd3, {4'h0, 6'h14}, 16'h0180);
    chk(mask_q, 1'b0);
    chk(irq_pending, 1'b0);
    chk(tx_data, 16'h1111);
    parity_err = 1'b1;
    dmc_range_end = 1'b1;
    for (n = 0; n < 20 && bus.dma_range_end_pulse !== 1'b1; n++) @(negedge clk);
    chk(n < 20, 1'b1);
    chk(panel_fault, 1'b1);
    {parity_err, dmc_range_end, power_valid, power_lost} = 4'b0001;
    repeat (15) @(negedge clk);
    chk(bus.power_fail_warning_n, 1'b0);
    power_lost = 1'b0;
    repeat (5) @(negedge clk);
    chk(bus.power_fail_warning_n, 1'b0);
    power_valid = 1'b1;
    repeat (15) @(negedge clk);
    chk(bus.power_fail_warning_n, 1'b1);
    clear_req = 1'b1;
    repeat (3) @(negedge clk);
    chk(bus.master_clear_level, 1'b1);
    chk(clear_seen, 1'b1);
    clear_req = 1'b0;
    repeat (3) @(negedge clk);
    chk(bus.master_clear_level, 1'b0);
    // second reset in mid-run
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    chk(bus.master_clear_level, 1'b1);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
